// [rtl/cstu_core.sv]
// Core storage transmit unit: execution of the storage-to-storage move instructions
// Function
// - Digit immediate writes Q units digit to P
// - Digit immediate also copies the units flag
// - Field move right to left until flag
// - Field move time grows per source digit
// - Immediate field move sources instruction Q digits
// - Floating move ignores flags in three lowest
// - Record move left to right until mark
// - Record move time grows per character
// - No-mark record move drops the record mark
// - Strip odd digits until numeric field flag
// - Zone 5 or 1 flags units digit
// - Zone 2 flags only a units zero
// - Strip erases old destination except field flag
// - Strip ignores zone flags, copies digit flags
// - Fill places digits at lower odd positions
// - Fill erases flags, terminator flag not copied
// - Fill zones: units 5 if negative, else 7
// - Record mark is the 8-2 digit code
`timescale 1ns/1ps
module cstu_core #(
  parameter logic [31:0] DIGIT_IMM_CYC  = 32'(cstu_pkg::DIGIT_IMM_CYC),
  parameter logic [31:0] FIELD_BASE_CYC = 32'(cstu_pkg::FIELD_BASE_CYC),
  parameter logic [31:0] FLOAT_BASE_CYC = 32'(cstu_pkg::FLOAT_BASE_CYC),
  parameter logic [31:0] MOVE_DIGIT_CYC = 32'(cstu_pkg::MOVE_DIGIT_CYC),
  parameter logic [31:0] CONV_BASE_CYC  = 32'(cstu_pkg::CONV_BASE_CYC),
  parameter logic [31:0] CONV_DIGIT_CYC = 32'(cstu_pkg::CONV_DIGIT_CYC)
) (
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    ce_i,
  input  wire logic                    cmd_valid_i,
  input  wire cstu_pkg::cstu_cmd_t     cmd_i,
  output logic                         cmd_ready_o,
  output cstu_pkg::cstu_mem_req_t      mem_o,
  input  wire cstu_pkg::cstu_cell_t    mem_rdata_i,
  output logic                         busy_o,
  output logic                         done_o,
  output logic                         bad_op_o,
  output logic [15:0]                  count_o
);

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_RD_SRC  = 3'b001,
    S_RD_ZONE = 3'b010,
    S_RD_DST  = 3'b011,
    S_WR_MAIN = 3'b100,
    S_WR_ZONE = 3'b101,
    S_HOLD    = 3'b110
  } cstu_state_t;

  typedef enum logic [1:0] {
    TAG_NONE = 2'b00,
    TAG_SRC  = 2'b01,
    TAG_ZONE = 2'b10,
    TAG_DST  = 2'b11
  } cstu_tag_t;

  cstu_state_t                     state;
  cstu_state_t                     next_state;
  cstu_tag_t                       pend_tag;
  logic [7:0]                      op;
  logic [cstu_pkg::ADDR_W-1:0]     src_addr;
  logic [cstu_pkg::ADDR_W-1:0]     dst_addr;
  cstu_pkg::cstu_cell_t [cstu_pkg::IMM_N-1:0] imm;
  cstu_pkg::cstu_cell_t            src_q;
  cstu_pkg::cstu_cell_t            zone_q;
  cstu_pkg::cstu_cell_t            dst_q;
  cstu_pkg::cstu_cell_t            src_v;
  cstu_pkg::cstu_cell_t            zone_v;
  cstu_pkg::cstu_cell_t            dst_v;
  cstu_pkg::cstu_cell_t            wr_cell;
  logic [15:0]                     cnt;
  logic [31:0]                     budget;
  logic [31:0]                     start_budget;
  logic [31:0]                     digit_cost;
  logic                            take;
  logic                            op_known;
  logic                            last;
  logic                            step;
  logic                            wr_en;
  logic                            rm_seen;
  logic                            neg_sign;

  assign take        = ce_i && cmd_valid_i && (state == S_IDLE);
  assign cmd_ready_o = (state == S_IDLE);
  assign busy_o      = (state != S_IDLE);
  assign count_o     = cnt;

  always_comb begin
    case (cmd_i.opcode)
      cstu_pkg::OP_DIGIT_IMM, cstu_pkg::OP_FIELD, cstu_pkg::OP_FIELD_IMM, cstu_pkg::OP_FLOAT,
      cstu_pkg::OP_RECORD, cstu_pkg::OP_RECORD_NM, cstu_pkg::OP_STRIP, cstu_pkg::OP_FILL: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase
  end

  // Read data arrives the cycle after the request; use it directly while pending
  assign src_v  = (pend_tag == TAG_SRC)  ? mem_rdata_i : src_q;
  assign zone_v = (pend_tag == TAG_ZONE) ? mem_rdata_i : zone_q;
  assign dst_v  = (pend_tag == TAG_DST)  ? mem_rdata_i : dst_q;

  assign rm_seen = (src_v.digit == cstu_pkg::RECORD_MARK);

  assign neg_sign = (zone_v.digit == cstu_pkg::ZONE_NEG_A) || (zone_v.digit == cstu_pkg::ZONE_NEG_B) ||
                    ((zone_v.digit == cstu_pkg::ZONE_NEG_ZERO) && (src_v.digit == cstu_pkg::DIGIT_ZERO));

  // Terminating position of each instruction
  always_comb begin
    case (op)
      cstu_pkg::OP_DIGIT_IMM: last = 1'b1;
      cstu_pkg::OP_FIELD:     last = src_v.flag && (cnt != 16'h0000);
      // immediate source is bounded by the Q part
      cstu_pkg::OP_FIELD_IMM: last = (imm[cnt[2:0]].flag && (cnt != 16'h0000)) ||
                                     (cnt == 16'(cstu_pkg::IMM_N - 1));
      cstu_pkg::OP_FLOAT:     last = src_v.flag && (cnt >= cstu_pkg::FLOAT_SKIP);
      cstu_pkg::OP_RECORD,
      cstu_pkg::OP_RECORD_NM: last = rm_seen;
      cstu_pkg::OP_STRIP:     last = dst_v.flag && (cnt != 16'h0000);
      // flagged leftmost digit is the last
      cstu_pkg::OP_FILL:      last = src_v.flag && (cnt != 16'h0000);
      default:                last = 1'b1;
    endcase
  end

  // Data written in the main write cycle
  always_comb begin
    wr_cell = src_v;
    wr_en   = 1'b1;
    case (op)
      cstu_pkg::OP_DIGIT_IMM: wr_cell = imm[0];
      cstu_pkg::OP_FIELD_IMM: wr_cell = imm[cnt[2:0]];
      cstu_pkg::OP_RECORD_NM: wr_en = !rm_seen;
      cstu_pkg::OP_STRIP: begin
        wr_cell.digit = src_v.digit;
        // keep field flag, copy odd-position flag
        if (cnt == 16'h0000) begin
          wr_cell.flag = neg_sign || src_v.flag;
        end else begin
          wr_cell.flag = dst_v.flag || src_v.flag;
        end
      end
      cstu_pkg::OP_FILL: begin
        wr_cell.flag  = 1'b0;
        wr_cell.digit = src_v.digit;
      end
      default: wr_cell = src_v;
    endcase
  end

  // Address steps after each completed position
  assign step = ce_i && (((state == S_WR_MAIN) && (op != cstu_pkg::OP_FILL)) || (state == S_WR_ZONE));

  // Storage request
  always_comb begin
    mem_o       = '0;
    mem_o.addr  = src_addr;
    case (state)
      S_RD_SRC: begin
        mem_o.req  = ce_i;
      end
      S_RD_ZONE: begin
        mem_o.req  = ce_i;
        mem_o.addr = src_addr - 16'h0001;
      end
      S_RD_DST: begin
        mem_o.req  = ce_i;
        mem_o.addr = dst_addr;
      end
      S_WR_MAIN: begin
        mem_o.req   = ce_i && wr_en;
        mem_o.we    = 1'b1;
        mem_o.addr  = dst_addr;
        mem_o.wdata = wr_cell;
      end
      S_WR_ZONE: begin
        mem_o.req         = ce_i;
        mem_o.we          = 1'b1;
        mem_o.addr        = dst_addr - 16'h0001;
        mem_o.wdata.flag  = 1'b0;
        mem_o.wdata.digit = ((cnt == 16'h0000) && src_v.flag) ? cstu_pkg::ZONE_MINUS : cstu_pkg::ZONE_PLUS;
      end
      default: mem_o.req = 1'b0;
    endcase
  end

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (take) begin
          if (!op_known) begin
            next_state = S_HOLD;
          end else if ((cmd_i.opcode == cstu_pkg::OP_DIGIT_IMM) || (cmd_i.opcode == cstu_pkg::OP_FIELD_IMM)) begin
            next_state = S_WR_MAIN;
          end else begin
            next_state = S_RD_SRC;
          end
        end
      end
      S_RD_SRC: begin
        if (op == cstu_pkg::OP_STRIP) begin
          next_state = (cnt == 16'h0000) ? S_RD_ZONE : S_RD_DST;
        end else begin
          next_state = S_WR_MAIN;
        end
      end
      S_RD_ZONE: next_state = S_RD_DST;
      S_RD_DST:  next_state = S_WR_MAIN;
      S_WR_MAIN: begin
        if (op == cstu_pkg::OP_FILL) begin
          next_state = S_WR_ZONE;
        end else if (last) begin
          next_state = S_HOLD;
        end else if (op == cstu_pkg::OP_FIELD_IMM) begin
          next_state = S_WR_MAIN;
        end else begin
          next_state = S_RD_SRC;
        end
      end
      S_WR_ZONE: next_state = last ? S_HOLD : S_RD_SRC;
      S_HOLD:    next_state = (budget == 32'h0000_0000) ? S_IDLE : S_HOLD;
      default:   next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= S_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Instruction capture
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op  <= 8'h00;
      imm <= '0;
    end else if (take) begin
      op  <= cmd_i.opcode;
      imm <= cmd_i.imm;
    end
  end

  // one or two positions per step (strip source and fill destination step two), direction by instruction
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_addr <= '0;
      dst_addr <= '0;
      cnt      <= cstu_pkg::CNT_RST;
    end else if (take) begin
      cnt      <= cstu_pkg::CNT_RST;
      src_addr <= (cmd_i.opcode == cstu_pkg::OP_STRIP) ? cmd_i.p_addr : cmd_i.q_addr;
      dst_addr <= (cmd_i.opcode == cstu_pkg::OP_STRIP) ? cmd_i.q_addr : cmd_i.p_addr;
    end else if (step) begin
      cnt <= cnt + 16'h0001;
      case (op)
        cstu_pkg::OP_RECORD, cstu_pkg::OP_RECORD_NM: begin
          src_addr <= src_addr + 16'h0001;
          dst_addr <= dst_addr + 16'h0001;
        end
        cstu_pkg::OP_STRIP: begin
          src_addr <= src_addr - 16'h0002;
          dst_addr <= dst_addr - 16'h0001;
        end
        cstu_pkg::OP_FILL: begin
          src_addr <= src_addr - 16'h0001;
          dst_addr <= dst_addr - 16'h0002;
        end
        default: begin
          src_addr <= src_addr - 16'h0001;
          dst_addr <= dst_addr - 16'h0001;
        end
      endcase
    end
  end

  // Read data capture
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_tag <= TAG_NONE;
      src_q    <= '0;
      zone_q   <= '0;
      dst_q    <= '0;
    end else if (ce_i) begin
      src_q  <= src_v;
      zone_q <= zone_v;
      dst_q  <= dst_v;
      case (state)
        S_RD_SRC:  pend_tag <= TAG_SRC;
        S_RD_ZONE: pend_tag <= TAG_ZONE;
        S_RD_DST:  pend_tag <= TAG_DST;
        default:   pend_tag <= TAG_NONE;
      endcase
    end
  end

  // Base time and per-position cost of each instruction
  always_comb begin
    start_budget = FIELD_BASE_CYC;
    case (cmd_i.opcode)
      cstu_pkg::OP_DIGIT_IMM: start_budget = DIGIT_IMM_CYC;
      cstu_pkg::OP_FLOAT:     start_budget = FLOAT_BASE_CYC;
      cstu_pkg::OP_STRIP,
      cstu_pkg::OP_FILL:      start_budget = CONV_BASE_CYC;
      default:                start_budget = op_known ? FIELD_BASE_CYC : 32'h0000_0000;
    endcase
    case (op)
      cstu_pkg::OP_DIGIT_IMM: digit_cost = 32'h0000_0000;
      cstu_pkg::OP_STRIP,
      cstu_pkg::OP_FILL:      digit_cost = CONV_DIGIT_CYC;
      default:                digit_cost = MOVE_DIGIT_CYC;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      budget <= cstu_pkg::BUDGET_RST;
    end else if (take) begin
      budget <= start_budget;
    end else if (ce_i) begin
      budget <= budget + (step ? digit_cost : 32'h0000_0000) -
                ((budget != 32'h0000_0000) ? 32'h0000_0001 : 32'h0000_0000);
    end
  end

  // Completion status
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_o   <= 1'b0;
      bad_op_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= (state == S_HOLD) && (budget == 32'h0000_0000);
      if (take) begin
        bad_op_o <= !op_known;
      end
    end
  end

endmodule : cstu_core

// [rtl/cstu_pkg.sv]
// Shared constants and types for the core storage transmit unit
package cstu_pkg;

  // Storage geometry and immediate Q part size
  localparam int ADDR_W = 16;
  localparam int IMM_N  = 5;

  // Opcodes, two decimal digits held as BCD
  localparam logic [7:0] OP_DIGIT_IMM   = 8'h15;
  localparam logic [7:0] OP_FIELD       = 8'h26;
  localparam logic [7:0] OP_FIELD_IMM   = 8'h16;
  localparam logic [7:0] OP_FLOAT       = 8'h06;
  localparam logic [7:0] OP_RECORD      = 8'h31;
  localparam logic [7:0] OP_RECORD_NM   = 8'h30;
  localparam logic [7:0] OP_STRIP       = 8'h72;
  localparam logic [7:0] OP_FILL        = 8'h73;

  // Digit codes: record mark is the 8-2 code (check bit not stored)
  localparam logic [3:0] RECORD_MARK    = 4'ha;
  localparam logic [3:0] ZONE_NEG_A     = 4'h5;
  localparam logic [3:0] ZONE_NEG_B     = 4'h1;
  localparam logic [3:0] ZONE_NEG_ZERO  = 4'h2;
  localparam logic [3:0] ZONE_PLUS      = 4'h7;
  localparam logic [3:0] ZONE_MINUS     = 4'h5;
  localparam logic [3:0] DIGIT_ZERO     = 4'h0;

  // Low-order positions whose flag does not end a floating move
  localparam logic [15:0] FLOAT_SKIP    = 16'h0003;

  // Reset values
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic [31:0] BUDGET_RST    = 32'h0000_0000;

  // Timing, in ns, and the clock period
  localparam int CLK_PERIOD_NS     = 5;
  localparam int T_DIGIT_IMM_NS    = 80000;
  localparam int T_FIELD_BASE_NS   = 65000;
  localparam int T_FLOAT_BASE_NS   = 95000;
  localparam int T_MOVE_DIGIT_NS   = 15000;
  localparam int T_CONV_BASE_NS    = 60000;
  localparam int T_CONV_DIGIT_NS   = 10000;

  // Least times rounded up to whole cycles
  localparam int DIGIT_IMM_CYC  = (T_DIGIT_IMM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIELD_BASE_CYC = (T_FIELD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_BASE_CYC = (T_FLOAT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MOVE_DIGIT_CYC = (T_MOVE_DIGIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_BASE_CYC  = (T_CONV_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_DIGIT_CYC = (T_CONV_DIGIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // One storage position: a decimal digit with its flag
  typedef struct packed {
    logic       flag;
    logic [3:0] digit;
  } cstu_cell_t;

  // Instruction handed to the unit; imm[0] is the units digit of Q
  typedef struct packed {
    logic [7:0]              opcode;
    logic [ADDR_W-1:0]       p_addr;
    logic [ADDR_W-1:0]       q_addr;
    cstu_cell_t [IMM_N-1:0]  imm;
  } cstu_cmd_t;

  // Storage access request
  typedef struct packed {
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    cstu_cell_t        wdata;
  } cstu_mem_req_t;

endpackage : cstu_pkg

// [sim/cstu_core_sva.sv]
// Concurrent checks on the transmit unit ports
`timescale 1ns/1ps
module cstu_core_sva #(
  parameter logic [31:0] DIGIT_IMM_CYC = 32'h0000_0014
) (
  input wire logic                    clk_i,
  input wire logic                    reset_n_i,
  input wire logic                    ce_i,
  input wire logic                    cmd_valid_i,
  input wire cstu_pkg::cstu_cmd_t     cmd_i,
  input wire logic                    cmd_ready_o,
  input wire cstu_pkg::cstu_mem_req_t mem_o,
  input wire cstu_pkg::cstu_cell_t    mem_rdata_i,
  input wire logic                    busy_o,
  input wire logic                    done_o,
  input wire logic                    bad_op_o,
  input wire logic [15:0]             count_o
);
  logic        take;
  logic        known_op;
  logic [7:0]  cur_op;
  logic [31:0] en_cnt;

  assign take     = ce_i && cmd_valid_i && cmd_ready_o;
  assign known_op = cmd_i.opcode inside {cstu_pkg::OP_DIGIT_IMM, cstu_pkg::OP_FIELD, cstu_pkg::OP_FIELD_IMM,
                    cstu_pkg::OP_FLOAT, cstu_pkg::OP_RECORD, cstu_pkg::OP_RECORD_NM, cstu_pkg::OP_STRIP,
                    cstu_pkg::OP_FILL};

  // Opcode of the running instruction and enabled cycles since its take
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur_op <= 8'h00;
      en_cnt <= 32'h0000_0000;
    end else if (take) begin
      cur_op <= cmd_i.opcode;
      en_cnt <= 32'h0000_0000;
    end else if (ce_i) begin
      en_cnt <= en_cnt + 32'h0000_0001;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence bad_resp_s;
    bad_op_o && !mem_o.req ##1 done_o;
  endsequence

  sequence dimm_write_s;
    mem_o.req && mem_o.we && mem_o.addr == $past(cmd_i.p_addr) && mem_o.wdata == $past(cmd_i.imm[0]);
  endsequence

  rst_idle_a: assert property (disable iff (1'b0) !reset_n_i |-> cmd_ready_o && !busy_o && !done_o
    && !mem_o.req && count_o == 16'h0000) else $error("outputs not idle in reset");
  ready_busy_a: assert property (cmd_ready_o != busy_o) else $error("ready and busy disagree");
  done_pulse_a: assert property (done_o && ce_i |=> !done_o) else $error("done longer than one cycle");
  done_ready_a: assert property (done_o |-> cmd_ready_o) else $error("done while not idle");
  idle_quiet_a: assert property (cmd_ready_o |-> !mem_o.req) else $error("storage access while idle");
  ce_gate_a: assert property (!ce_i |-> !mem_o.req) else $error("storage access while frozen");
  bad_op_a: assert property (take && !known_op |-> ##1 bad_resp_s) else $error("unknown opcode handling");
  dimm_write_a: assert property (take && cmd_i.opcode == cstu_pkg::OP_DIGIT_IMM |=> (!ce_i) or dimm_write_s)
    else $error("digit immediate write wrong");
  dimm_time_a: assert property (done_o && cur_op == cstu_pkg::OP_DIGIT_IMM |->
    en_cnt >= DIGIT_IMM_CYC && en_cnt <= DIGIT_IMM_CYC + 32'h3) else $error("digit immediate time wrong");
  nm_skip_a: assert property (busy_o && cur_op == cstu_pkg::OP_RECORD_NM && mem_o.req && mem_o.we |->
    mem_o.wdata.digit != cstu_pkg::RECORD_MARK) else $error("record mark written");
  fill_clear_a: assert property (busy_o && cur_op == cstu_pkg::OP_FILL && mem_o.req && mem_o.we |->
    !mem_o.wdata.flag) else $error("fill wrote a flag");
endmodule : cstu_core_sva

bind cstu_core cstu_core_sva #(.DIGIT_IMM_CYC(DIGIT_IMM_CYC)) u_sva (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .mem_o(mem_o),
  .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o), .bad_op_o(bad_op_o), .count_o(count_o));

// [sim/cstu_core_tb.sv]
// Self-checking bench for the core storage transmit unit
`timescale 1ns/1ps
module cstu_core_tb;
  localparam logic [31:0] P_DIMM = 32'h14;
  localparam logic [31:0] P_FB   = 32'ha;
  localparam logic [31:0] P_FLB  = 32'hc;
  localparam logic [31:0] P_MD   = 32'h4;

  logic                    clk_i;
  logic                    reset_n_i;
  logic                    ce_i = 1'b1;
  logic                    cmd_valid_i;
  logic                    cmd_ready_o;
  logic                    busy_o;
  logic                    done_o;
  logic                    bad_op_o;
  logic                    stall_en;
  logic [15:0]             count_o;
  cstu_pkg::cstu_cmd_t     cmd_i;
  cstu_pkg::cstu_mem_req_t mem_o;
  cstu_pkg::cstu_cell_t    mem_rdata_i;
  int                      fail_count;
  int                      checks_done;
  int                      cyc;
  int                      tick;

  cstu_core #(.DIGIT_IMM_CYC(P_DIMM), .FIELD_BASE_CYC(P_FB), .FLOAT_BASE_CYC(P_FLB), .MOVE_DIGIT_CYC(P_MD),
    .CONV_BASE_CYC(32'h8), .CONV_DIGIT_CYC(32'h3)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .mem_o(mem_o),
    .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o), .bad_op_o(bad_op_o), .count_o(count_o));
  cstu_mem_model u_mem (.clk_i(clk_i), .ce_i(ce_i), .req_i(mem_o), .rdata_o(mem_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Optional freeze of every fifth cycle
  always @(posedge clk_i) begin
    tick <= tick + 1;
    ce_i <= !(stall_en && tick % 5 == 0);
  end

  function automatic cstu_pkg::cstu_cell_t cl(input logic f, input logic [3:0] d);
    return {f, d};
  endfunction : cl

  function automatic cstu_pkg::cstu_cmd_t mc(input logic [7:0] op, input logic [15:0] p, input logic [15:0] q);
    cstu_pkg::cstu_cmd_t c;
    c = '0;
    c.opcode = op;
    c.p_addr = p;
    c.q_addr = q;
    return c;
  endfunction : mc

  task automatic chk_cell(input cstu_pkg::cstu_cell_t got, input cstu_pkg::cstu_cell_t exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cell

  task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_num

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Offer one instruction, then wait for its completion pulse
  task automatic go(input cstu_pkg::cstu_cmd_t c);
    int n;
    n = 0;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i       <= c;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ce_i && cmd_ready_o) && n < 100);
    if (!(ce_i && cmd_ready_o)) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, n, 0);
      tally_and_finish();
    end
    cmd_valid_i <= 1'b0;
    cyc = 0;
    while (done_o !== 1'b1) begin
      @(negedge clk_i);
      cyc++;
      if (cyc > 3000) begin
        fail_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, cyc, 0);
        tally_and_finish();
      end
    end
  endtask : go

  // Compare n moved cells, then m-n cells that must keep the preset
  task automatic cmp_span(input logic [15:0] s, input logic [15:0] d, input int n, input int m, input int dir);
    for (int i = 0; i < m; i++) begin
      chk_cell(u_mem.mem[16'(d + dir * i)], i < n ? u_mem.mem[16'(s + dir * i)] : cl(1'b1, 4'h9));
    end
  endtask : cmp_span

  task automatic preset(input logic [15:0] d, input int m, input int dir);
    for (int i = 0; i < m; i++) begin
      u_mem.mem[16'(d + dir * i)] = cl(1'b1, 4'h9);
    end
  endtask : preset

  task automatic t_moves;
    cstu_pkg::cstu_cmd_t c;
    c = mc(cstu_pkg::OP_DIGIT_IMM, 16'h0100, 16'h0000);
    c.imm[0] = cl(1'b1, 4'h7);
    c.imm[1] = cl(1'b0, 4'h2);
    u_mem.mem[16'h0100] = cl(1'b0, 4'h3);
    go(c);
    chk_cell(u_mem.mem[16'h0100], cl(1'b1, 4'h7));
    chk_num(32'(cyc >= P_DIMM), 32'h1);
    u_mem.mem[16'h0205] = cl(1'b1, 4'h4);
    u_mem.mem[16'h0204] = cl(1'b0, 4'h1);
    u_mem.mem[16'h0203] = cl(1'b1, 4'h2);
    preset(16'h0305, 4, -1);
    stall_en = 1'b1;
    go(mc(cstu_pkg::OP_FIELD, 16'h0305, 16'h0205));
    stall_en = 1'b0;
    cmp_span(16'h0205, 16'h0305, 3, 4, -1);
    chk_num({16'h0, count_o}, 32'h3);
    chk_num(32'(cyc >= P_FB + 3 * P_MD), 32'h1);
    c = mc(cstu_pkg::OP_FIELD_IMM, 16'h0310, 16'h0000);
    c.imm[0] = cl(1'b0, 4'h3);
    c.imm[1] = cl(1'b0, 4'h8);
    c.imm[2] = cl(1'b1, 4'h6);
    preset(16'h0310, 4, -1);
    go(c);
    for (int i = 0; i < 4; i++) chk_cell(u_mem.mem[16'h0310 - 16'(i)], i < 3 ? c.imm[i] : cl(1'b1, 4'h9));
    for (int i = 0; i < 6; i++) u_mem.mem[16'h0409 - 16'(i)] = cl(i == 1 || i == 2 || i == 4, 4'(i + 1));
    preset(16'h0509, 6, -1);
    go(mc(cstu_pkg::OP_FLOAT, 16'h0509, 16'h0409));
    cmp_span(16'h0409, 16'h0509, 5, 6, -1);
    chk_num(32'(cyc >= P_FLB + 5 * P_MD), 32'h1);
    $display("field moves done");
  endtask : t_moves

  task automatic t_records;
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 3; i++) u_mem.mem[16'h0600 + 16'(i)] = cl(i == 0, 4'(i + 1));
      u_mem.mem[16'h0603] = cl(1'b0, cstu_pkg::RECORD_MARK);
      preset(16'h0700, 5, 1);
      go(mc(k == 0 ? cstu_pkg::OP_RECORD : cstu_pkg::OP_RECORD_NM, 16'h0700, 16'h0600));
      cmp_span(16'h0600, 16'h0700, 4 - k, 5, 1);
    end
    $display("record moves done");
  endtask : t_records

  task automatic t_strip;
    logic [3:0] zz [5];
    logic [3:0] dd [5];
    logic       ef [5];
    zz = '{4'h5, 4'h1, 4'h2, 4'h2, 4'h7};
    dd = '{4'h4, 4'h4, 4'h0, 4'h5, 4'h4};
    ef = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int k = 0; k < 5; k++) begin
      u_mem.mem[16'h0801] = cl(1'b0, dd[k]);
      u_mem.mem[16'h0800] = cl(1'b0, zz[k]);
      u_mem.mem[16'h07ff] = cl(1'b0, 4'h3);
      u_mem.mem[16'h07fe] = cl(1'b1, 4'h7);
      u_mem.mem[16'h07fd] = cl(1'b0, 4'h2);
      u_mem.mem[16'h07fc] = cl(1'b0, 4'h7);
      u_mem.mem[16'h07fb] = cl(1'b0, 4'h1);
      u_mem.mem[16'h07fa] = cl(1'b0, 4'h7);
      preset(16'h0905, 5, -1);
      u_mem.mem[16'h0904] = cl(1'b0, 4'h9);
      u_mem.mem[16'h0903] = cl(1'b0, 4'h9);
      u_mem.mem[16'h0901] = cl(1'b0, 4'h9);
      go(mc(cstu_pkg::OP_STRIP, 16'h0801, 16'h0905));
      chk_cell(u_mem.mem[16'h0905], cl(ef[k], dd[k]));
      chk_cell(u_mem.mem[16'h0904], cl(1'b0, 4'h3));
      chk_cell(u_mem.mem[16'h0903], cl(1'b0, 4'h2));
      chk_cell(u_mem.mem[16'h0902], cl(1'b1, 4'h1));
      chk_cell(u_mem.mem[16'h0901], cl(1'b0, 4'h9));
      chk_cell(u_mem.mem[16'h07fe], cl(1'b1, 4'h7));
    end
    $display("numeric strip done");
  endtask : t_strip

  task automatic t_fill;
    logic [3:0] nd [4];
    nd = '{4'h7, 4'h8, 4'h9, 4'h1};
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 4; i++) u_mem.mem[16'h0a05 - 16'(i)] = cl(i == 3 || (i == 0 && k == 1), nd[i]);
      preset(16'h0b07, 9, -1);
      go(mc(cstu_pkg::OP_FILL, 16'h0b07, 16'h0a05));
      for (int i = 0; i < 4; i++) begin
        chk_cell(u_mem.mem[16'h0b07 - 16'(2 * i)], cl(1'b0, nd[i]));
        chk_cell(u_mem.mem[16'h0b06 - 16'(2 * i)], cl(1'b0, (i == 0 && k == 1) ? 4'h5 : 4'h7));
      end
      chk_cell(u_mem.mem[16'h0aff], cl(1'b1, 4'h9));
      chk_cell(u_mem.mem[16'h0a02], cl(1'b1, 4'h1));
    end
    go(mc(8'h99, 16'h0100, 16'h0000));
    chk_num({31'h0, bad_op_o}, 32'h1);
    chk_cell(u_mem.mem[16'h0100], cl(1'b1, 4'h7));
    $display("fill and bad opcode done");
  endtask : t_fill

  initial begin
    reset_n_i   = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i       = '0;
    stall_en    = 1'b0;
    fail_count  = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_i);
    chk_num({28'h0, cmd_ready_o, busy_o, done_o, bad_op_o}, 32'h8);
    reset_n_i <= 1'b1;
    t_moves();
    t_records();
    t_strip();
    t_fill();
    tally_and_finish();
  end
endmodule : cstu_core_tb

// [sim/cstu_mem_model.sv]
// Core storage model: flagged digits, one-cycle read latency
`timescale 1ns/1ps
module cstu_mem_model (
  input  wire logic                    clk_i,
  input  wire logic                    ce_i,
  input  wire cstu_pkg::cstu_mem_req_t req_i,
  output cstu_pkg::cstu_cell_t         rdata_o
);
  cstu_pkg::cstu_cell_t mem [0:65535];

  always @(posedge clk_i) begin
    if (ce_i) begin
      if (req_i.req && req_i.we) begin
        mem[req_i.addr] <= req_i.wdata;
      end
      // Data not read this cycle is garbage, not the last value
      if (req_i.req && !req_i.we) begin
        rdata_o <= mem[req_i.addr];
      end else begin
        rdata_o <= ~rdata_o;
      end
    end
  end
endmodule : cstu_mem_model
